// ===== common/watchdog_pkg.sv
// shared constants, modes and carriers of the watchdog block
package watchdog_pkg;

  // -------------------------------------------------------------
  // counter and period select
  // -------------------------------------------------------------
  localparam int CNT_W = 23;
  localparam int PS_W = 5;
  localparam int RATIO_MIN_LOG2 = 5;
  localparam logic [4:0] PS_RESET = 5'h0b;
  localparam logic [4:0] PS_MAX = 5'h12;

  // -------------------------------------------------------------
  // configuration mode codes
  // -------------------------------------------------------------
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_SOFT = 2'h1;
  localparam logic [1:0] MODE_AWAKE = 2'h2;
  localparam logic [1:0] MODE_ALWAYS = 2'h3;

  // -------------------------------------------------------------
  // register map (byte addresses) and fields
  // -------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_MASK = 8'h08;
  localparam logic [7:0] ADDR_STATE = 8'h0c;
  localparam logic [7:0] ADDR_COUNT = 8'h10;
  localparam int CTRL_SWEN_BIT = 0;
  localparam int CTRL_PS_LSB = 1;
  localparam int CTRL_PS_MSB = 5;
  localparam logic SWEN_RESET = 1'b0;
  localparam int EVT_W = 3;
  localparam int EVT_TO_AWAKE = 0;
  localparam int EVT_TO_SLEEP = 1;
  localparam int EVT_OSC_FAIL = 2;
  localparam int STATE_ACTIVE_BIT = 0;
  localparam int STATE_ASLEEP_BIT = 1;
  localparam int STATE_MODE_LSB = 2;
  localparam int STATE_HOLD_BIT = 4;

  // -------------------------------------------------------------
  // timing
  // -------------------------------------------------------------
  localparam int PCLK_MHZ = 50;
  localparam int LF_OSC_KHZ = 31;
  localparam int BASE_INTERVAL_MS = 1;
  localparam int LF_PERIOD_CYCLES = (PCLK_MHZ * 1000) / LF_OSC_KHZ;
  localparam int SYNC_MIN_CYCLES = 4;

  // -------------------------------------------------------------
  // power state and carriers
  // -------------------------------------------------------------
  typedef enum logic {ST_AWAKE, ST_ASLEEP} power_state_e;

  typedef struct packed {
    logic clear_watchdog_instr;
    logic sleep_enter;
    logic wake_event;
    logic osc_fail;
  } core_evt_s;

  typedef struct packed {
    logic sys_clk_crystal;
    logic osc_startup_timer;
  } osc_ctrl_s;

endpackage

// ===== verilog/lf_tick_sync.sv
// two-flop synchroniser and rising-edge tick for the low-frequency oscillator
module lf_tick_sync
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // asynchronous level
  input wire logic async_in,
  // one-cycle pulse per rising edge
  output logic tick
);

  logic meta_ff;
  logic sync_ff;
  logic last_ff;

  // -------------------------------------------------------------
  // synchroniser: meta_ff feeds sync_ff only
  // -------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      last_ff <= 1'b0;
    end
    else
    begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
    end
  end

  assign tick = sync_ff & ~last_ff;

endmodule

// ===== verilog/period_decode.sv
// period select code to terminal count of the watchdog counter
module period_decode
  import watchdog_pkg::*;
#(
  parameter int CW = CNT_W
)
(
  // select code
  input wire logic [PS_W-1:0] sel,
  // last count value before a time-out
  output logic [CW-1:0] term
);

  // -------------------------------------------------------------
  // elaboration check: the widest ratio must fit
  // -------------------------------------------------------------
  // the widest ratio is 2**(RATIO_MIN_LOG2+PS_MAX); its terminal count needs that many bits
  if (CW < RATIO_MIN_LOG2 + int'(PS_MAX))
  begin : g_bad_width
    $error("counter too narrow for the widest ratio");
  end

  logic [CW:0] ratio;

  always_comb
  begin
    if (sel > PS_MAX)
      ratio = (CW+1)'(1) << RATIO_MIN_LOG2; // [R08]
    else
      ratio = (CW+1)'(1) << (RATIO_MIN_LOG2 + int'(sel)); // [R06]
  end

  assign term = CW'(ratio - (CW+1)'(1));

endmodule

// ===== verilog/watchdog_timer_block.sv
// watchdog timer with apb registers, sleep handling and interrupt
// -------------------------------------------------------------
// Contract
// [R01] count low-frequency oscillator ticks, never the cpu clock; base interval 1 ms
// [R02] mode 00 disables the watchdog whatever the enable bit or sleep
// [R03] mode 11 keeps the watchdog active always, sleep included; enable ignored
// [R04] mode 10 active while awake, disabled in sleep; enable ignored
// [R05] mode 01 runs only while soft enable is 1; sleep irrelevant
// [R06] period code 00000 gives 1:32, each step doubles, up to 10010
// [R07] after reset period select holds 01011, ratio 1:65536
// [R08] codes 10011 to 11111 act as the minimum ratio 1:32
// [R09] count cleared on reset, clear instruction, sleep, wake, osc fail, disable
// [R10] crystal clock: held clear while startup timer runs; else cleared once
// [R11] internal oscillator divider changes leave the watchdog untouched
// [R12] sleep entry clears the count; counting resumes if enabled in sleep
// [R13] time-out in sleep wakes the device, no reset; status bits updated
// [R14] control bits 7-6 read zero; period and enable are read/write
// [R15] time-out while awake requests a device reset
// [R16] count reaching the selected ratio signals time-out and restarts at zero
// -------------------------------------------------------------
//
// Register access over APB and the address map are this design's own decisions.
module watchdog_timer_block
  import watchdog_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [watchdog_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // configuration word
  input wire logic [1:0] watchdog_mode_cfg,
  // independent oscillator pin
  input wire logic low_freq_internal_osc,
  // core and oscillator control
  input wire watchdog_pkg::core_evt_s core_evt,
  input wire watchdog_pkg::osc_ctrl_s osc_ctrl,
  // results
  output logic reset_req,
  output logic wake_req,
  output logic timeout_status_n,
  output logic powerdown_status_n,
  output logic irq
);

  // -------------------------------------------------------------
  // declarations
  // -------------------------------------------------------------
  logic lf_tick;
  logic [CNT_W-1:0] term_cnt;
  logic [CNT_W-1:0] watchdog_counter_ff;
  logic [PS_W-1:0] timeout_period_sel_ff;
  logic soft_watchdog_on_ff;
  logic [EVT_W-1:0] stat_ff;
  logic [EVT_W-1:0] mask_ff;
  power_state_e pstate_ff;
  power_state_e nxt_pstate;
  logic active;
  logic ost_hold;
  logic clr_cnt;
  logic hit;
  logic timeout;
  logic [EVT_W-1:0] evt_set;
  logic setup;
  logic access;
  logic wr_en;
  logic mapped;
  logic [31:0] nxt_prdata;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic reset_req_ff;
  logic wake_req_ff;
  logic to_n_ff;
  logic pd_n_ff;
  logic irq_ff;

  // -------------------------------------------------------------
  // oscillator tick and period decode
  // -------------------------------------------------------------
  // the counter advances only on these ticks, so the cpu clock and its
  // divider setting never change the time-out
  lf_tick_sync u_lf_sync
  (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(low_freq_internal_osc), // [R01] [R11]
    .tick(lf_tick)
  );

  period_decode #(.CW(CNT_W)) u_decode
  (
    .sel(timeout_period_sel_ff),
    .term(term_cnt)
  );

  // -------------------------------------------------------------
  // mode decode
  // -------------------------------------------------------------
  always_comb
  begin
    unique case (watchdog_mode_cfg)
      MODE_ALWAYS: active = 1'b1; // [R03]
      MODE_AWAKE: active = (pstate_ff == ST_AWAKE); // [R04]
      MODE_SOFT: active = soft_watchdog_on_ff; // [R05]
      MODE_OFF: active = 1'b0; // [R02]
    endcase
  end

  // -------------------------------------------------------------
  // counter
  // -------------------------------------------------------------
  // a crystal clock is not trusted until its startup timer ends; other
  // clocks see only the single clear from the wake event
  assign ost_hold = osc_ctrl.sys_clk_crystal & osc_ctrl.osc_startup_timer; // [R10]

  assign clr_cnt = ~active | core_evt.clear_watchdog_instr | core_evt.sleep_enter
    | core_evt.wake_event | core_evt.osc_fail | ost_hold; // [R09]

  // a shorter period written mid-count must not let the counter run past its end
  assign hit = lf_tick && (watchdog_counter_ff >= term_cnt);
  assign timeout = hit & ~clr_cnt; // [R16]

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      watchdog_counter_ff <= '0; // [R09]
    else if (clr_cnt)
      watchdog_counter_ff <= '0; // [R09] [R12]
    else if (timeout)
      watchdog_counter_ff <= '0; // [R16]
    else if (lf_tick)
      watchdog_counter_ff <= watchdog_counter_ff + CNT_W'(1);
  end

  // -------------------------------------------------------------
  // power state
  // -------------------------------------------------------------
  always_comb
  begin
    nxt_pstate = pstate_ff;
    unique case (pstate_ff)
      ST_AWAKE:
      begin
        if (core_evt.sleep_enter)
          nxt_pstate = ST_ASLEEP;
      end
      ST_ASLEEP:
      begin
        if (core_evt.wake_event || timeout)
          nxt_pstate = ST_AWAKE; // [R13]
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pstate_ff <= ST_AWAKE;
    else
      pstate_ff <= nxt_pstate;
  end

  // -------------------------------------------------------------
  // reset and wake requests, status bits
  // -------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      reset_req_ff <= 1'b0;
      wake_req_ff <= 1'b0;
    end
    else
    begin
      reset_req_ff <= timeout && (pstate_ff == ST_AWAKE); // [R15]
      wake_req_ff <= timeout && (pstate_ff == ST_ASLEEP); // [R13]
    end
  end

  // both status bits read one after power-up; a time-out drops the first
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      to_n_ff <= 1'b1;
      pd_n_ff <= 1'b1;
    end
    else if (timeout)
    begin
      to_n_ff <= 1'b0; // [R13] [R15]
      pd_n_ff <= (pstate_ff == ST_AWAKE); // [R13]
    end
    else if (core_evt.sleep_enter && pstate_ff == ST_AWAKE)
    begin
      to_n_ff <= 1'b1;
      pd_n_ff <= 1'b0;
    end
    else if (core_evt.clear_watchdog_instr)
    begin
      to_n_ff <= 1'b1;
      pd_n_ff <= 1'b1;
    end
  end

  // -------------------------------------------------------------
  // apb decode
  // -------------------------------------------------------------
  assign setup = psel & ~penable;
  assign access = psel & penable & pready_ff;
  assign wr_en = access & pwrite & ~pslverr_ff;

  always_comb
  begin
    mapped = 1'b1;
    nxt_prdata = '0;
    unique case (paddr)
      ADDR_CTRL:
      begin
        // bits 7-6 and above stay zero
        nxt_prdata[CTRL_PS_MSB:CTRL_PS_LSB] = timeout_period_sel_ff; // [R14]
        nxt_prdata[CTRL_SWEN_BIT] = soft_watchdog_on_ff; // [R14]
      end
      ADDR_STAT: nxt_prdata[EVT_W-1:0] = stat_ff;
      ADDR_MASK: nxt_prdata[EVT_W-1:0] = mask_ff;
      ADDR_STATE:
      begin
        nxt_prdata[STATE_ACTIVE_BIT] = active;
        nxt_prdata[STATE_ASLEEP_BIT] = (pstate_ff == ST_ASLEEP);
        nxt_prdata[STATE_MODE_LSB+1:STATE_MODE_LSB] = watchdog_mode_cfg;
        nxt_prdata[STATE_HOLD_BIT] = ost_hold;
      end
      ADDR_COUNT: nxt_prdata[CNT_W-1:0] = watchdog_counter_ff;
      default: mapped = 1'b0;
    endcase
  end

  // answer in the first access cycle: no wait states
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= '0;
    end
    else if (setup)
    begin
      pready_ff <= 1'b1;
      pslverr_ff <= ~mapped;
      prdata_ff <= pwrite ? '0 : nxt_prdata;
    end
    else
    begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= '0;
    end
  end

  // -------------------------------------------------------------
  // control register
  // -------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      timeout_period_sel_ff <= PS_RESET; // [R07]
      soft_watchdog_on_ff <= SWEN_RESET;
    end
    else if (wr_en && paddr == ADDR_CTRL)
    begin
      timeout_period_sel_ff <= pwdata[CTRL_PS_MSB:CTRL_PS_LSB]; // [R14]
      soft_watchdog_on_ff <= pwdata[CTRL_SWEN_BIT]; // [R14]
    end
  end

  // -------------------------------------------------------------
  // event status, mask and interrupt
  // -------------------------------------------------------------
  always_comb
  begin
    evt_set = '0;
    evt_set[EVT_TO_AWAKE] = timeout && (pstate_ff == ST_AWAKE);
    evt_set[EVT_TO_SLEEP] = timeout && (pstate_ff == ST_ASLEEP);
    evt_set[EVT_OSC_FAIL] = core_evt.osc_fail;
  end

  // a set in the same cycle as a write-one clear wins, so no event is lost
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      stat_ff <= '0;
    else if (wr_en && paddr == ADDR_STAT)
      stat_ff <= (stat_ff & ~pwdata[EVT_W-1:0]) | evt_set;
    else
      stat_ff <= stat_ff | evt_set;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mask_ff <= '0;
    else if (wr_en && paddr == ADDR_MASK)
      mask_ff <= pwdata[EVT_W-1:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_ff <= 1'b0;
    else
      irq_ff <= |(stat_ff & mask_ff);
  end

  // -------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign reset_req = reset_req_ff;
  assign wake_req = wake_req_ff;
  assign timeout_status_n = to_n_ff;
  assign powerdown_status_n = pd_n_ff;
  assign irq = irq_ff;

endmodule

// ===== verif/watchdog_sva.sv
// assertion checker on the watchdog block ports
module watchdog_sva
  import watchdog_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic [watchdog_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // control
  input wire logic [1:0] watchdog_mode_cfg,
  input wire logic low_freq_internal_osc,
  input wire watchdog_pkg::core_evt_s core_evt,
  input wire watchdog_pkg::osc_ctrl_s osc_ctrl,
  // results
  input wire logic reset_req,
  input wire logic wake_req,
  input wire logic timeout_status_n,
  input wire logic powerdown_status_n,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_reset_pulse;
    reset_req |=> !reset_req [*8];
  endproperty
  a_reset_pulse: assert property (p_reset_pulse) else $error("reset request too long");
  property p_wake_pulse;
    wake_req |=> !wake_req [*8];
  endproperty
  a_wake_pulse: assert property (p_wake_pulse) else $error("wake request too long");
  property p_awake_status;
    reset_req |-> !timeout_status_n && powerdown_status_n && !wake_req;
  endproperty
  a_awake_status: assert property (p_awake_status) else $error("awake time-out status");
  property p_sleep_status;
    wake_req |-> !timeout_status_n && !powerdown_status_n;
  endproperty
  a_sleep_status: assert property (p_sleep_status) else $error("sleep time-out status");
  property p_clear_status;
    core_evt.clear_watchdog_instr |=> timeout_status_n && powerdown_status_n;
  endproperty
  a_clear_status: assert property (p_clear_status) else $error("clear status");
  // any core event (clear, sleep, wake, osc fail) at the terminal tick must swallow the time-out
  property p_clear_supp;
    core_evt != '0 |=> !reset_req && !wake_req;
  endproperty
  a_clear_supp: assert property (p_clear_supp) else $error("time-out despite clear");
  property p_startup_hold;
    osc_ctrl.sys_clk_crystal && osc_ctrl.osc_startup_timer |=> !reset_req && !wake_req;
  endproperty
  a_startup_hold: assert property (p_startup_hold) else $error("time-out during startup hold");
  property p_off;
    watchdog_mode_cfg == MODE_OFF && $past(watchdog_mode_cfg) == MODE_OFF |-> !reset_req && !wake_req;
  endproperty
  a_off: assert property (p_off) else $error("time-out while off");
  property p_ctrl_top;
    pready && !pslverr && !pwrite && paddr == ADDR_CTRL |-> prdata[31:6] == 26'h0;
  endproperty
  a_ctrl_top: assert property (p_ctrl_top) else $error("control top bits set");
endmodule

bind watchdog_timer_block watchdog_sva watchdog_sva_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .watchdog_mode_cfg(watchdog_mode_cfg), .low_freq_internal_osc(low_freq_internal_osc),
  .core_evt(core_evt), .osc_ctrl(osc_ctrl), .reset_req(reset_req), .wake_req(wake_req),
  .timeout_status_n(timeout_status_n), .powerdown_status_n(powerdown_status_n), .irq(irq));

// ===== verif/lf_osc_model.sv
// low-frequency oscillator as the core side supplies it
module lf_osc_model
#(
  parameter int HALF_NS = 85
)
(
  // control
  input wire logic run,
  // oscillator pin
  output logic osc
);
  timeunit 1ns;
  timeprecision 1ps;
  // period is not a whole number of pclk cycles, so ticks drift against the clock
  initial
  begin
    osc = 1'b0;
    forever
    begin
      #(HALF_NS);
      osc = run ? ~osc : 1'b0;
    end
  end
endmodule

// ===== verif/watchdog_timer_block_test.sv
// self-checking bench of the watchdog block
module watchdog_timer_block_test
  import watchdog_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF_NS = 85;
  localparam core_evt_s EV_CLR = 4'h8;
  localparam core_evt_s EV_SLEEP = 4'h4;
  localparam core_evt_s EV_WAKE = 4'h2;
  localparam core_evt_s EV_FAIL = 4'h1;
  localparam logic [4:0] SELS [4] = '{5'h00, 5'h01, 5'h13, 5'h1f};
  localparam int RATIOS [4] = '{32, 64, 32, 32};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, osc_run, low_freq_internal_osc;
  logic reset_req, wake_req, timeout_status_n, powerdown_status_n, irq;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [1:0] watchdog_mode_cfg;
  core_evt_s core_evt;
  osc_ctrl_s osc_ctrl;
  int error_cnt, samples_checked, n;

  watchdog_timer_block watchdog_timer_block_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .watchdog_mode_cfg(watchdog_mode_cfg), .low_freq_internal_osc(low_freq_internal_osc), .core_evt(core_evt),
    .osc_ctrl(osc_ctrl), .reset_req(reset_req), .wake_req(wake_req), .timeout_status_n(timeout_status_n),
    .powerdown_status_n(powerdown_status_n), .irq(irq));
  lf_osc_model #(.HALF_NS(HALF_NS)) lf_osc_model_inst (.run(osc_run), .osc(low_freq_internal_osc));

  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  task automatic report_and_stop;
    if (error_cnt == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'b1)
    begin
      error_cnt++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  // one apb transfer; waits on pready, never on a fixed count
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
    output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] x, input logic xe, input string msg);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    check(q === x && e === xe, msg);
  endtask

  task automatic pulse(input core_evt_s ev);
    @(posedge pclk);
    core_evt <= ev;
    @(posedge pclk);
    core_evt <= '0;
  endtask

  // cycles until the chosen request is seen, lim if it never comes
  task automatic wait_req(input logic wake, input int lim, output int cyc);
    cyc = 0;
    do
    begin
      @(posedge pclk);
      cyc++;
    end
    while ((wake ? wake_req : reset_req) !== 1'b1 && cyc < lim);
  endtask

  function automatic int exp_cyc(input int ratio);
    return ratio * 2 * HALF_NS / 20;
  endfunction

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    watchdog_mode_cfg = MODE_OFF;
    core_evt = '0;
    osc_ctrl = '0;
    osc_run = 1'b1;
    error_cnt = 0;
    samples_checked = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(ADDR_CTRL, 32'h16, 1'b0, "control reset value");
    wr(ADDR_CTRL, 32'hff);
    rd_chk(ADDR_CTRL, 32'h3f, 1'b0, "control read back");
    rd_chk(8'h40, 32'h0, 1'b1, "unmapped access");
    watchdog_mode_cfg <= MODE_SOFT;
    foreach (SELS[i])
    begin
      wr(ADDR_CTRL, {26'h0, SELS[i], 1'b1});
      pulse(EV_CLR);
      wait_req(1'b0, 1200, n);
      wait_req(1'b0, 1200, n);
      check(n >= exp_cyc(RATIOS[i]) - 2 && n <= exp_cyc(RATIOS[i]) + 2, "time-out period");
    end
    watchdog_mode_cfg <= MODE_OFF;
    wait_req(1'b0, 600, n);
    check(n == 600, "time-out while off");
    watchdog_mode_cfg <= MODE_SOFT;
    wr(ADDR_CTRL, 32'h0);
    wait_req(1'b0, 600, n);
    check(n == 600, "time-out with soft enable low");
    watchdog_mode_cfg <= MODE_ALWAYS;
    osc_run <= 1'b0;
    wait_req(1'b0, 600, n);
    check(n == 600, "counting without oscillator");
    osc_run <= 1'b1;
    wait_req(1'b0, 600, n);
    check(n < 600, "always-on ignores soft enable");
    osc_ctrl <= 2'b11;
    wait_req(1'b0, 600, n);
    check(n == 600, "time-out during startup timer");
    osc_ctrl <= 2'b10;
    wait_req(1'b0, 320, n);
    check(n < 320, "count after startup timer");
    pulse(EV_SLEEP);
    wait_req(1'b1, 600, n);
    check(n >= exp_cyc(32) - 12 && n <= exp_cyc(32) + 4, "sleep count from zero");
    check(!timeout_status_n && !powerdown_status_n, "sleep time-out status");
    watchdog_mode_cfg <= MODE_AWAKE;
    pulse(EV_SLEEP);
    wait_req(1'b1, 600, n);
    check(n == 600 && reset_req === 1'b0, "time-out in sleep while off in sleep");
    rd_chk(ADDR_STATE, 32'ha, 1'b0, "state while asleep and disabled");
    rd_chk(ADDR_COUNT, 32'h0, 1'b0, "count held clear while disabled");
    pulse(EV_WAKE);
    wait_req(1'b0, 320, n);
    check(n < 320, "awake time-out");
    // clearing well inside the period must hold the time-out off
    repeat (5)
    begin
      wait_req(1'b0, 200, n);
      check(n == 200, "time-out despite clear");
      pulse(EV_CLR);
    end
    watchdog_mode_cfg <= MODE_OFF;
    wr(ADDR_STAT, 32'h7);
    rd_chk(ADDR_STAT, 32'h0, 1'b0, "status cleared");
    wr(ADDR_MASK, 32'h4);
    pulse(EV_FAIL);
    rd_chk(ADDR_STAT, 32'h4, 1'b0, "oscillator fail status");
    check(irq === 1'b1, "interrupt raised");
    wr(ADDR_MASK, 32'h0);
    repeat (2) @(posedge pclk);
    check(irq === 1'b0, "interrupt masked");
    wr(ADDR_MASK, 32'h4);
    repeat (2) @(posedge pclk);
    check(irq === 1'b1, "interrupt unmasked");
    wr(ADDR_STAT, 32'h4);
    repeat (2) @(posedge pclk);
    check(irq === 1'b0, "interrupt cleared");
    // a second reset in mid-run must restore the control defaults
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    check(timeout_status_n === 1'b1 && powerdown_status_n === 1'b1 && irq === 1'b0, "outputs after reset");
    rd_chk(ADDR_CTRL, 32'h16, 1'b0, "control after second reset");
    rd_chk(ADDR_COUNT, 32'h0, 1'b0, "count after second reset");
    report_and_stop();
  end

  initial
  begin
    repeat (40000) @(posedge pclk);
    error_cnt++;
    $display("unexpected at %0t: run timed out", $time);
    report_and_stop();
  end
endmodule
